// ---- shared/dme_consts.vh ----
// constants for the data-memory and eeprom access block
`ifndef DME_CONSTS_VH
`define DME_CONSTS_VH

// ----------------------------------------------------------------
// data space layout
// ----------------------------------------------------------------
`define DME_REGFILE_BASE   16'h0000
`define DME_IO_BASE        16'h0020
`define DME_SRAM_BASE      16'h0060
`define DME_SRAM_LAST      16'h045F
`define DME_SRAM_BYTES     1024
`define DME_EE_BYTES       512

// ----------------------------------------------------------------
// eeprom access registers, as io indices (data address = 0x20 + index)
// ----------------------------------------------------------------
`define DME_IO_EE_ADDR_HI  6'h1F
`define DME_IO_EE_ADDR_LO  6'h1E
`define DME_IO_EE_DATA     6'h1D
`define DME_IO_EE_CTRL     6'h1C

// ----------------------------------------------------------------
// control register fields and reset values
// ----------------------------------------------------------------
`define DME_CTRL_READ_BIT  0
`define DME_CTRL_WRITE_BIT 1
`define DME_CTRL_ARM_BIT   2
`define DME_CTRL_RESET     8'h00
`define DME_DATA_RESET     8'h00

// ----------------------------------------------------------------
// timing
// ----------------------------------------------------------------
`define DME_ARM_WINDOW     3'h4
`define DME_READ_STALL     3'h4
`define DME_WRITE_STALL    3'h2
`define DME_WR_RC_CYCLES   8448
`define DME_RC_FREQ_HZ     1000000
`define DME_CLK_FREQ_HZ    25000000
// write time in core cycles, rounded up
`define DME_WR_CYCLES      ((`DME_WR_RC_CYCLES * (`DME_CLK_FREQ_HZ / 1000) + (`DME_RC_FREQ_HZ / 1000) - 1) / (`DME_RC_FREQ_HZ / 1000))

`endif

// ---- src/dme_ram.v ----
// byte-wide single-port memory with registered read data
`timescale 1ns/100ps
module dme_ram #(
    parameter AW = 10,
    parameter DEPTH = 1024
) (
    // clock
    input  wire          i_clk,
    // access
    input  wire [AW-1:0] i_addr,
    input  wire          i_we,
    input  wire [7:0]    i_wdata,
    output reg  [7:0]    o_rdata
);

    reg [7:0] mem_ff [0:DEPTH-1];

    // ----------------------------------------------------------------
    // storage
    // ----------------------------------------------------------------
    // no reset: array contents are undefined at power-up, as real cells
    always @(posedge i_clk) begin
        if (i_we) begin
            mem_ff[i_addr] <= i_wdata;
        end
        o_rdata <= mem_ff[i_addr];
    end

endmodule

// ---- src/dme_top.v ----
// data-space decode, internal sram and data eeprom access registers
`timescale 1ns/100ps
`include "dme_consts.vh"

// Behaviour
// - low 1120 locations: first 96 regfile/io, next 1024 sram
// - 32 working registers, then 64 io registers, then 1024 sram bytes
// - every sram access finishes in two core cycles
// - 512-byte eeprom, separate space, byte read and write
// - eeprom address, data, control registers sit in io space
// - writes are self-timed; write strobe bit polls busy
// - eeprom write only after arm-then-strobe; other attempts ignored
// - eeprom read stalls the core four cycles
// - eeprom write stalls the core two cycles
// - address bits 15..9 read as zero
// - address field bits 8..0, linear 0..511
// - address has no reset value; software loads it first
// - write stores data register at the address register
// - read loads data register from the address register
// - arm bit cleared after four cycles; strobe needs arm set
// - write strobe bit clears itself when write time elapses
// - write timed by 8448 cycles of the 1 MHz rc oscillator
// - read data is in the data register within the same instruction
module dme_top #(
    parameter WR_CYCLES = `DME_WR_CYCLES
) (
    // clock and reset
    input  wire        i_clk,
    input  wire        i_reset_n,
    // core data-space access, one request cycle each
    input  wire        i_req,
    input  wire        i_we,
    input  wire [15:0] i_addr,
    input  wire [7:0]  i_wdata,
    // answer
    output reg         o_ack,
    output reg  [7:0]  o_rdata,
    output reg         o_stall,
    output reg         o_ee_busy
);

    // ----------------------------------------------------------------
    // reset release
    // ----------------------------------------------------------------
    reg rst_meta_ff;
    reg rst_n_ff;
    always @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            rst_meta_ff <= 1'b0;
            rst_n_ff    <= 1'b0;
        end else begin
            rst_meta_ff <= 1'b1;
            rst_n_ff    <= rst_meta_ff;
        end
    end

    // ----------------------------------------------------------------
    // decode helpers
    // ----------------------------------------------------------------
    localparam RGN_REG  = 2'h0;
    localparam RGN_IO   = 2'h1;
    localparam RGN_SRAM = 2'h2;
    localparam RGN_NONE = 2'h3;

    function [1:0] region;
        input [15:0] a;
        begin
            if (a < `DME_IO_BASE)
                region = RGN_REG;
            else if (a < `DME_SRAM_BASE)
                region = RGN_IO;
            else if (a <= `DME_SRAM_LAST)
                region = RGN_SRAM;
            else
                region = RGN_NONE;
        end
    endfunction

    // ----------------------------------------------------------------
    // storage: working registers and io in one memory, sram in another
    // ----------------------------------------------------------------
    wire [7:0]  low_rdata;      // 32 working + 64 io, eeprom regs read elsewhere
    wire [7:0]  sram_rdata;
    wire [7:0]  ee_rdata;
    wire [15:0] sram_off = i_addr - `DME_SRAM_BASE;
    wire [15:0] io_off   = i_addr - `DME_IO_BASE;
    wire [9:0]  sram_idx = sram_off[9:0];
    wire [1:0]  rgn      = region(i_addr);
    wire [5:0]  io_idx   = io_off[5:0];
    wire        io_hit   = i_req && (rgn == RGN_IO);
    wire        low_we   = i_req && i_we && (rgn == RGN_REG || rgn == RGN_IO);

    dme_ram #(.AW(10), .DEPTH(`DME_SRAM_BYTES)) u_sram (
        .i_clk   (i_clk),
        .i_addr  (sram_idx),
        .i_we    (i_req && i_we && (rgn == RGN_SRAM)),
        .i_wdata (i_wdata),
        .o_rdata (sram_rdata)
    );

    // working and io registers; registered read keeps the same two-cycle answer
    dme_ram #(.AW(7), .DEPTH(96)) u_low (
        .i_clk   (i_clk),
        .i_addr  (i_addr[6:0]),
        .i_we    (low_we),
        .i_wdata (i_wdata),
        .o_rdata (low_rdata)
    );

    // ----------------------------------------------------------------
    // eeprom registers
    // ----------------------------------------------------------------
    reg  [8:0] ee_addr_ff;      // no reset value by design
    reg  [7:0] ee_data_ff;
    reg        arm_ff;
    reg  [2:0] arm_cnt_ff;
    reg        wstrobe_ff;
    reg  [31:0] wr_cnt_ff;
    reg  [2:0] stall_cnt_ff;
    reg        ee_we;

    wire ctrl_wr   = io_hit && i_we && (io_idx == `DME_IO_EE_CTRL);
    wire set_arm   = ctrl_wr && i_wdata[`DME_CTRL_ARM_BIT];
    wire set_read  = ctrl_wr && i_wdata[`DME_CTRL_READ_BIT] && !wstrobe_ff;
    wire set_write = ctrl_wr && i_wdata[`DME_CTRL_WRITE_BIT] && arm_ff && !wstrobe_ff;

    // eeprom array; read port reads the live address
    dme_ram #(.AW(9), .DEPTH(`DME_EE_BYTES)) u_ee (
        .i_clk   (i_clk),
        .i_addr  (ee_addr_ff),
        .i_we    (ee_we),
        .i_wdata (ee_data_ff),
        .o_rdata (ee_rdata)
    );

    // address register, locked during writes
    always @(posedge i_clk) begin
        if (io_hit && i_we && !wstrobe_ff) begin
            if (io_idx == `DME_IO_EE_ADDR_HI)
                ee_addr_ff[8] <= i_wdata[0];
            if (io_idx == `DME_IO_EE_ADDR_LO)
                ee_addr_ff[7:0] <= i_wdata;
        end
    end

    // arm window, write timer, stall counter, data register
    reg rd_pend_ff;
    always @(posedge i_clk or negedge rst_n_ff) begin
        if (!rst_n_ff) begin
            arm_ff       <= 1'b0;
            arm_cnt_ff   <= 3'h0;
            wstrobe_ff   <= 1'b0;
            wr_cnt_ff    <= 32'h0;
            stall_cnt_ff <= 3'h0;
            ee_data_ff   <= `DME_DATA_RESET;
            ee_we        <= 1'b0;
            rd_pend_ff   <= 1'b0;
        end else begin
            ee_we      <= 1'b0;
            rd_pend_ff <= 1'b0;
            if (set_arm && !set_write) begin
                arm_ff     <= 1'b1;
                arm_cnt_ff <= `DME_ARM_WINDOW;
            end else if (set_write) begin
                arm_ff     <= 1'b0;
            end else if (arm_cnt_ff != 3'h0) begin
                arm_cnt_ff <= arm_cnt_ff - 3'h1;
                if (arm_cnt_ff == 3'h1)
                    arm_ff <= 1'b0;
            end
            if (set_write) begin
                wstrobe_ff   <= 1'b1;
                wr_cnt_ff    <= WR_CYCLES;
                ee_we        <= 1'b1;
                stall_cnt_ff <= `DME_WRITE_STALL;
            end else if (wstrobe_ff) begin
                if (wr_cnt_ff <= 32'h1)
                    wstrobe_ff <= 1'b0;
                wr_cnt_ff <= wr_cnt_ff - 32'h1;
            end
            if (set_read) begin
                rd_pend_ff   <= 1'b1;
                stall_cnt_ff <= `DME_READ_STALL;
            end else if (!set_write && stall_cnt_ff != 3'h0) begin
                stall_cnt_ff <= stall_cnt_ff - 3'h1;
            end
            if (rd_pend_ff)
                ee_data_ff <= ee_rdata;
            else if (io_hit && i_we && io_idx == `DME_IO_EE_DATA)
                ee_data_ff <= i_wdata;
        end
    end

    // ----------------------------------------------------------------
    // answer: two-cycle access, read data registered
    // ----------------------------------------------------------------
    reg        acc_ff;
    reg [1:0]  acc_rgn_ff;
    reg [15:0] acc_addr_ff;
    reg [7:0]  nxt_rdata;
    wire [15:0] acc_off = acc_addr_ff - `DME_IO_BASE;
    wire [5:0]  acc_io  = acc_off[5:0];

    // low space read value chosen combinationally in the second cycle
    always @* begin
        case (acc_rgn_ff)
            RGN_SRAM: nxt_rdata = sram_rdata;
            RGN_REG:  nxt_rdata = low_rdata;
            RGN_IO: begin
                case (acc_io)
                    `DME_IO_EE_ADDR_HI: nxt_rdata = {7'h00, ee_addr_ff[8]};
                    `DME_IO_EE_ADDR_LO: nxt_rdata = ee_addr_ff[7:0];
                    `DME_IO_EE_DATA:    nxt_rdata = ee_data_ff;
                    `DME_IO_EE_CTRL:    nxt_rdata = {5'h00, arm_ff, wstrobe_ff, 1'b0};
                    default:            nxt_rdata = low_rdata;
                endcase
            end
            default:  nxt_rdata = 8'h00;
        endcase
    end

    always @(posedge i_clk or negedge rst_n_ff) begin
        if (!rst_n_ff) begin
            acc_ff      <= 1'b0;
            acc_rgn_ff  <= RGN_NONE;
            acc_addr_ff <= 16'h0000;
            o_ack       <= 1'b0;
            o_rdata     <= 8'h00;
            o_stall     <= 1'b0;
            o_ee_busy   <= 1'b0;
        end else begin
            acc_ff      <= i_req;
            acc_rgn_ff  <= rgn;
            acc_addr_ff <= i_addr;
            o_ack       <= acc_ff;
            o_rdata     <= acc_ff ? nxt_rdata : 8'h00;
            o_stall     <= set_read || set_write || (stall_cnt_ff > 3'h1);
            o_ee_busy   <= wstrobe_ff || set_write;
        end
    end

endmodule

// ---- dv/dme_asserts.sv ----
// port checks for the data-memory and eeprom access block
`timescale 1ns/100ps
module dme_asserts #(
    parameter WR_CYCLES = 20
) (
    input wire        i_clk,
    input wire        i_reset_n,
    input wire        i_req,
    input wire        i_we,
    input wire [15:0] i_addr,
    input wire [7:0]  i_wdata,
    input wire        o_ack,
    input wire [7:0]  o_rdata,
    input wire        o_stall,
    input wire        o_ee_busy
);
    localparam logic [15:0] CTRL = 16'h003C;
    logic [31:0] busy_cnt_ff;
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!i_reset_n);
    // ----------------------------------------------------------------
    // helper: cycles spent in the current self-timed write
    // ----------------------------------------------------------------
    always_ff @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n)
            busy_cnt_ff <= 32'h0;
        else
            busy_cnt_ff <= o_ee_busy ? busy_cnt_ff + 32'h1 : 32'h0;
    end
    // ----------------------------------------------------------------
    // access timing and read data
    // ----------------------------------------------------------------
    a_ack_delay: assert property (i_req |-> ##2 o_ack)
        else $error("ack not two cycles after request");
    a_ack_cause: assert property (o_ack |-> $past(i_req, 2))
        else $error("ack without request");
    a_rdata_idle: assert property (!o_ack |-> o_rdata == 8'h00)
        else $error("read data outside ack");
    a_above_zero: assert property (i_req && !i_we && i_addr > 16'h045F |-> ##2 o_rdata == 8'h00)
        else $error("read above sram not zero");
    // ----------------------------------------------------------------
    // eeprom stalls and busy period
    // ----------------------------------------------------------------
    a_read_stall: assert property (i_req && i_we && i_addr == CTRL && i_wdata == 8'h01 && !o_ee_busy
        |=> o_stall [*4] ##1 !o_stall) else $error("read stall not four cycles");
    a_write_stall: assert property ($rose(o_ee_busy) |-> o_stall ##1 o_stall ##1 !o_stall)
        else $error("write stall not two cycles");
    a_busy_cause: assert property ($rose(o_ee_busy) |-> $past(i_req && i_we && i_addr == CTRL && i_wdata[1]))
        else $error("busy without write strobe");
    a_stall_cause: assert property ($rose(o_stall) |-> $past(i_req && i_we && i_addr == CTRL))
        else $error("stall without control write");
    a_busy_length: assert property ($fell(o_ee_busy) |-> busy_cnt_ff >= WR_CYCLES - 2
        && busy_cnt_ff <= WR_CYCLES + 2) else $error("write time off");
endmodule

// ---- dv/dme_cpu_model.sv ----
// cpu-side model: byte accesses and the eeprom access sequences
`timescale 1ns/100ps
module dme_cpu_model (
    // clock
    input  wire         i_clk,
    // answer from the block
    input  wire         i_ack,
    input  wire [7:0]   i_rdata,
    input  wire         i_stall,
    // request to the block
    output logic        o_req,
    output logic        o_we,
    output logic [15:0] o_addr,
    output logic [7:0]  o_wdata
);
    localparam logic [15:0] CTRL = 16'h003C;
    // idle bus at time zero
    initial begin
        o_req = 1'b0;
        o_we = 1'b0;
        o_addr = 16'h0000;
        o_wdata = 8'h00;
    end
    // one request cycle, then wait for ack and the end of any stall
    task automatic access(input logic w, input logic [15:0] a, input logic [7:0] d, input int gap,
                          output logic [7:0] rd);
        int k;
        repeat (gap + 1) @(negedge i_clk);
        o_req = 1'b1;
        o_we = w;
        o_addr = a;
        o_wdata = d;
        @(negedge i_clk);
        // released lines flip so stale values never pass for good ones
        o_req = 1'b0;
        o_we = ~w;
        o_addr = ~a;
        o_wdata = ~d;
        for (k = 0; k < 4 && i_ack !== 1'b1; k++) @(negedge i_clk);
        rd = (i_ack === 1'b1) ? i_rdata : 8'hXX;
        for (k = 0; k < 8 && i_stall !== 1'b0; k++) @(negedge i_clk);
    endtask
    // poll the write strobe bit until the self-timed write is over
    task automatic ee_wait(output logic [7:0] rd);
        int k;
        rd = 8'hFF;
        for (k = 0; k < 200 && rd[1] !== 1'b0; k++) access(1'b0, CTRL, 8'h00, 0, rd);
    endtask
    // late above one lets the arm lapse before the strobe
    task automatic ee_write(input logic [8:0] ea, input logic [7:0] d, input int late);
        logic [7:0] rd;
        ee_wait(rd);
        access(1'b1, 16'h003F, {7'h00, ea[8]}, 0, rd);
        access(1'b1, 16'h003E, ea[7:0], 0, rd);
        access(1'b1, 16'h003D, d, 0, rd);
        access(1'b1, CTRL, 8'h04, 0, rd);
        access(1'b1, CTRL, 8'h02, late, rd);
    endtask
    task automatic ee_read(input logic [8:0] ea, output logic [7:0] rd);
        ee_wait(rd);
        access(1'b1, 16'h003F, {7'h00, ea[8]}, 0, rd);
        access(1'b1, 16'h003E, ea[7:0], 0, rd);
        access(1'b1, CTRL, 8'h01, 0, rd);
        access(1'b0, 16'h003D, 8'h00, 0, rd);
    endtask
endmodule

// ---- dv/tb_top.sv ----
// testbench top: cpu model driving the data-memory and eeprom block
`timescale 1ns/100ps
module tb_top;
    localparam int          WR = 20;
    localparam logic [15:0] CTRL = 16'h003C;
    logic        i_clk, i_reset_n, req, we, ack, stall, busy;
    logic [15:0] addr, a;
    logic [7:0]  wdata, rdata, rd, d;
    logic [8:0]  ea;
    logic [31:0] rng;
    int          failures, n_compared, cyc, i;
    logic [15:0] corner [5] = '{16'h0000, 16'h001F, 16'h0020, 16'h0060, 16'h045F};
    // short write time keeps the run brief
    dme_top #(.WR_CYCLES(WR)) uut (.i_clk(i_clk), .i_reset_n(i_reset_n), .i_req(req), .i_we(we), .i_addr(addr),
        .i_wdata(wdata), .o_ack(ack), .o_rdata(rdata), .o_stall(stall), .o_ee_busy(busy));
    dme_cpu_model cpu (.i_clk(i_clk), .i_ack(ack), .i_rdata(rdata), .i_stall(stall), .o_req(req), .o_we(we),
        .o_addr(addr), .o_wdata(wdata));
    function automatic logic [31:0] rnd();
        rng = rng ^ (rng << 13);
        rng = rng ^ (rng >> 17);
        rng = rng ^ (rng << 5);
        return rng;
    endfunction
    // only address bit 8 survives in the high byte
    function automatic logic [7:0] exp_hi(input logic [7:0] v);
        return {7'h00, v[0]};
    endfunction
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        n_compared++;
        if (got !== exp) begin
            failures++;
            $display("MISMATCH t=%0t got %h expected %h", $time, got, exp);
        end
    endtask
    task complete_run;
        if (failures == 0 && n_compared > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask
    // ----------------------------------------------------------------
    // clock and hang guard
    // ----------------------------------------------------------------
    always #20 i_clk = ~i_clk;
    always @(posedge i_clk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            failures++;
            complete_run();
        end
    end
    // ----------------------------------------------------------------
    // main sequence
    // ----------------------------------------------------------------
    initial begin
        i_clk = 1'b0;
        i_reset_n = 1'b0;
        rng = 32'd57594;
        failures = 0;
        n_compared = 0;
        repeat (3) @(negedge i_clk);
        i_reset_n = 1'b1;
        repeat (3) @(negedge i_clk);
        // register file, io and sram: boundaries first, then random sram
        for (i = 0; i < 16; i++) begin
            a = (i < 5) ? corner[i] : 16'h0060 + 16'(rnd() % 1024);
            d = 8'(rnd());
            cpu.access(1'b1, a, d, int'(rnd() % 3), rd);
            cpu.access(1'b0, a, 8'h00, int'(rnd() % 3), rd);
            chk(rd, d);
        end
        // beyond the last sram byte nothing sticks
        for (i = 0; i < 2; i++) begin
            a = (i == 0) ? 16'h0460 : 16'hFFFF;
            cpu.access(1'b1, a, 8'hA5, 0, rd);
            cpu.access(1'b0, a, 8'h00, 0, rd);
            chk(rd, 8'h00);
        end
        cpu.access(1'b1, 16'h003F, 8'hFF, 0, rd);
        cpu.access(1'b0, 16'h003F, 8'h00, 0, rd);
        chk(rd, exp_hi(8'hFF));
        // eeprom: both ends of the space, then random
        for (i = 0; i < 4; i++) begin
            ea = (i == 0) ? 9'h000 : (i == 1) ? 9'h1FF : 9'(rnd());
            d = 8'(rnd());
            cpu.ee_write(ea, d, 0);
            cpu.access(1'b1, 16'h003E, ~ea[7:0], 0, rd);
            cpu.access(1'b0, CTRL, 8'h00, 0, rd);
            chk(rd & 8'h07, 8'h02);
            cpu.ee_wait(rd);
            chk(rd & 8'h02, 8'h00);
            cpu.access(1'b0, 16'h003E, 8'h00, 0, rd);
            chk(rd, ea[7:0]);
            cpu.ee_read(ea, rd);
            chk(rd, d);
        end
        // strobe with no arm, then strobe after the arm lapsed
        cpu.access(1'b1, 16'h003D, ~d, 0, rd);
        cpu.access(1'b1, CTRL, 8'h02, 0, rd);
        chk({7'h00, busy}, 8'h00);
        cpu.ee_write(ea, ~d, 6);
        chk({7'h00, busy}, 8'h00);
        cpu.ee_read(ea, rd);
        chk(rd, d);
        complete_run();
    end
endmodule
bind dme_top dme_asserts #(.WR_CYCLES(WR_CYCLES)) u_chk (.i_clk(i_clk), .i_reset_n(i_reset_n), .i_req(i_req),
    .i_we(i_we), .i_addr(i_addr), .i_wdata(i_wdata), .o_ack(o_ack), .o_rdata(o_rdata), .o_stall(o_stall),
    .o_ee_busy(o_ee_busy));
